// ===== shared/tlpu_consts.vh
// Constants of the packet user interface.
`ifndef TLPU_CONSTS_VH
`define TLPU_CONSTS_VH

// Word width of the four-lane, two-lane and downgraded variants.
`define TLPU_WIDE_W      64
// Word width of the native single-lane variant.
`define TLPU_NARROW_W    16
// Depth of the transmit staging buffer in words.
`define TLPU_FIFO_DEPTH  4
// Number of address windows checked on receive.
`define TLPU_BAR_NUM     7
// Header sizes in doublewords.
`define TLPU_HDR3_DW     11'h003
`define TLPU_HDR4_DW     11'h004
// Bit positions inside the first header doubleword.
`define TLPU_FMT_DATA    30
`define TLPU_FMT_4DW     29
`define TLPU_DIGEST      15
`define TLPU_LEN_MSB     9
// Format and type bytes of configuration accesses aimed at the core's own registers.
`define TLPU_CFG0_RD     8'h04
`define TLPU_CFG0_WR     8'h44
// Type field values of memory and I/O requests.
`define TLPU_TYPE_MEM    5'h00
`define TLPU_TYPE_MEML   5'h01
`define TLPU_TYPE_IO     5'h02

`endif

// ===== rtl/tlpu_core.v
// Packet user interface: transmit grant and buffer, receive filter, credit return.
//
// Overview of operation
// - First word with start mark comes the cycle after the grant.
// - Grant stays high until one cycle before the last data cycle; here it also drops while the transmit buffer has no room.
// - Word width is 64 bits except the native single-lane variant.
// - Native single-lane variant carries 16-bit words.
// - Lower layers add framing, sequence number and link CRC.
// - Configuration accesses to core registers are consumed; others forwarded.
// - Enabled windows are checked; hits flagged on seven bits.
// - Start mark on first word, rest on following cycles, end mark on last.
// - CRC error flag rises in the final cycle.
// - Malformed flag may rise in any cycle of the packet.
// - At least one idle cycle between an end mark and the next start.
// - Packets leave no faster than they arrive, so gaps may appear.

`include "tlpu_consts.vh"

// Transmit staging buffer with first-word-fall-through output.
module tlpu_fifo #(
    parameter W     = 66,
    parameter DEPTH = `TLPU_FIFO_DEPTH,
    parameter AW    = 2
) (
    // Clock and reset.
    input  wire          mclk,
    input  wire          sys_rst,
    // Filling side.
    input  wire          in_valid,
    output wire          in_ready,
    input  wire [W-1:0]  in_data,
    // Draining side.
    output wire          out_valid,
    input  wire          out_ready,
    output wire [W-1:0]  out_data,
    // Fill level.
    output reg  [AW:0]   level
);
    reg [W-1:0]  mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    wire         push;
    wire         pop;

    assign in_ready  = (level != DEPTH[AW:0]);
    assign out_valid = (level != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage has no reset; only the pointers and level define what is valid.
    always @(posedge mclk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    // Pointers wrap at the depth, which need not be a power of two.
    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            level  <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            if (push && !pop)
                level <= level + 1'b1;
            else if (pop && !push)
                level <= level - 1'b1;
        end
    end
endmodule

module tlpu_core #(
    parameter DATA_W = `TLPU_WIDE_W,
    parameter DEPTH  = `TLPU_FIFO_DEPTH,
    parameter AW     = 2
) (
    // Clock and reset.
    input  wire                     mclk,
    input  wire                     sys_rst,
    // Transmit, user side.
    input  wire                     xmit_request,
    output wire                     xmit_grant,
    input  wire                     xmit_start_mark,
    input  wire                     xmit_end_mark,
    input  wire [DATA_W-1:0]        xmit_data,
    // Far-end credit, user side.
    output reg  [7:0]               far_posted_hdr_credit,
    output reg  [11:0]              far_posted_data_credit,
    output reg  [7:0]               far_nonposted_hdr_credit,
    output reg  [11:0]              far_nonposted_data_credit,
    output reg                      far_posted_hdr_unlim,
    output reg                      far_posted_data_unlim,
    output reg                      far_nonposted_hdr_unlim,
    output reg                      far_nonposted_data_unlim,
    output reg                      posted_credit_recheck,
    output reg                      completion_credit_recheck,
    // Far-end credit, link side.
    input  wire [8:0]               link_ph_credit,
    input  wire [12:0]              link_pd_credit,
    input  wire [8:0]               link_nph_credit,
    input  wire [12:0]              link_npd_credit,
    input  wire                     link_p_recheck,
    input  wire                     link_cpl_recheck,
    // Transmit, link side.
    output wire                     link_tx_valid,
    input  wire                     link_tx_ready,
    output wire                     link_tx_start,
    output wire                     link_tx_end,
    output wire [DATA_W-1:0]        link_tx_data,
    // Receive, link side.
    input  wire                     link_rx_valid,
    output wire                     link_rx_ready,
    input  wire                     link_rx_start,
    input  wire                     link_rx_end,
    input  wire                     link_rx_crc_err,
    input  wire                     link_rx_len_err,
    input  wire [DATA_W-1:0]        link_rx_data,
    // Address windows.
    input  wire [6:0]               bar_enable,
    input  wire [7*32-1:0]          bar_base,
    input  wire [7*32-1:0]          bar_mask,
    // Receive, user side.
    output reg                      recv_valid,
    output reg                      recv_start_mark,
    output reg                      recv_end_mark,
    output reg  [DATA_W-1:0]        recv_data,
    output reg  [6:0]               recv_bar_hit,
    output reg                      recv_crc_error_flag,
    output reg                      recv_malformed_flag,
    output reg                      cfg_consumed,
    // Credit return, user to link.
    input  wire                     posted_hdr_credit_return,
    input  wire                     posted_data_credit_return,
    input  wire [7:0]               posted_data_credit_count,
    input  wire                     nonposted_hdr_credit_return,
    output reg                      link_ph_release,
    output reg                      link_pd_release,
    output reg  [7:0]               link_pd_count,
    output reg                      link_nph_release
);
    // Whole words in a three-doubleword header, rounded down: 96 bits over the word width (1 at 64 bits).
    localparam [12:0] MIN_W = 13'd96 / DATA_W;

    // Packet length in words from its first header doubleword.
    function [12:0] tlpu_words;
        input [31:0] dw0;
        reg   [10:0] dws;
        reg   [10:0] len;
        begin
            len = (dw0[`TLPU_LEN_MSB:0] == 10'h000) ? 11'h400 : {1'b0, dw0[`TLPU_LEN_MSB:0]};
            dws = dw0[`TLPU_FMT_4DW] ? `TLPU_HDR4_DW : `TLPU_HDR3_DW;
            if (dw0[`TLPU_FMT_DATA])
                dws = dws + len;
            if (dw0[`TLPU_DIGEST])
                dws = dws + 11'h001;
            tlpu_words = (({2'b00, dws} << 5) + DATA_W[12:0] - 13'h0001) / DATA_W[12:0];
        end
    endfunction

    reg          tx_act;
    reg          tx_due;
    reg          tx_known;
    reg  [12:0]  tx_total;
    reg  [12:0]  tx_issued;
    reg  [12:0]  tx_rcvd;
    reg          rechk_q;
    wire [31:0]  dw0_now;
    wire         dw0_done;
    wire [12:0]  total_eff;
    wire         known_eff;
    wire         room;
    wire         tx_last;
    wire         fifo_in_ready;
    wire [AW:0]  fifo_level;

    // Header doubleword: whole in the first wide word, assembled over narrow words.
    generate
        if (DATA_W >= 32)
        begin : g_wide
            assign dw0_now  = xmit_data[DATA_W-1 -: 32];
            assign dw0_done = tx_due && (tx_rcvd == 13'h0000);
        end
        else
        begin : g_narrow
            reg [31:0] hdr_sh;
            assign dw0_now  = {hdr_sh[31-DATA_W:0], xmit_data};
            assign dw0_done = tx_due && (tx_rcvd == (13'd32 / DATA_W) - 13'h0001);
            always @(posedge mclk or posedge sys_rst)
            begin
                if (sys_rst)
                    hdr_sh <= 32'h0000_0000;
                else if (tx_due)
                    hdr_sh <= dw0_now;
            end
        end
    endgenerate

    assign total_eff = dw0_done ? tlpu_words(dw0_now) : tx_total;
    assign known_eff = tx_known || dw0_done;
    assign tx_last   = tx_due && (xmit_end_mark || (known_eff && tx_rcvd + 13'h0001 == total_eff));

    // A granted word lands next cycle, so count it against the room.
    assign room = fifo_in_ready && (({1'b0, fifo_level} + {{AW{1'b0}}, tx_due}) < DEPTH);

    // Grant waits out a recheck so the user has a cycle to withdraw; during a packet
    // it runs while words remain and the buffer has room, and ends one cycle before the last data cycle.
    assign xmit_grant = !tx_act
        ? (xmit_request && room && !posted_credit_recheck && !completion_credit_recheck && !rechk_q)
        : (room && !tx_last && (tx_issued < MIN_W || (known_eff && tx_issued < total_eff)));

    // Transmit packet tracking; data is expected the cycle after each grant.
    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tx_act    <= 1'b0;
            tx_due    <= 1'b0;
            tx_known  <= 1'b0;
            tx_total  <= 13'h0000;
            tx_issued <= 13'h0000;
            tx_rcvd   <= 13'h0000;
            rechk_q   <= 1'b0;
        end
        else
        begin
            rechk_q <= posted_credit_recheck || completion_credit_recheck;
            tx_due  <= xmit_grant;
            if (!tx_act)
            begin
                tx_known <= 1'b0;
                tx_rcvd  <= 13'h0000;
                if (xmit_grant)
                begin
                    tx_act    <= 1'b1;
                    tx_issued <= 13'h0001;
                end
            end
            else
            begin
                if (xmit_grant)
                    tx_issued <= tx_issued + 13'h0001;
                if (dw0_done)
                begin
                    tx_known <= 1'b1;
                    tx_total <= total_eff;
                end
                if (tx_due)
                    tx_rcvd <= tx_rcvd + 13'h0001;
                if (tx_last)
                    tx_act <= 1'b0;
            end
        end
    end

    // Words pass unframed; link layers add framing and CRC.
    tlpu_fifo #(.W(DATA_W + 2), .DEPTH(DEPTH), .AW(AW)) u_fifo (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .in_valid  (tx_due),
        .in_ready  (fifo_in_ready),
        .in_data   ({xmit_start_mark, xmit_end_mark, xmit_data}),
        .out_valid (link_tx_valid),
        .out_ready (link_tx_ready),
        .out_data  ({link_tx_start, link_tx_end, link_tx_data}),
        .level     (fifo_level)
    );

    // Credit view and rechecks, registered toward the user.
    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            far_posted_hdr_credit <= 8'h00;
            far_posted_data_credit <= 12'h000;
            far_nonposted_hdr_credit <= 8'h00;
            far_nonposted_data_credit <= 12'h000;
            far_posted_hdr_unlim <= 1'b0;
            far_posted_data_unlim <= 1'b0;
            far_nonposted_hdr_unlim <= 1'b0;
            far_nonposted_data_unlim <= 1'b0;
            posted_credit_recheck <= 1'b0;
            completion_credit_recheck <= 1'b0;
            link_ph_release <= 1'b0;
            link_pd_release <= 1'b0;
            link_pd_count <= 8'h00;
            link_nph_release <= 1'b0;
        end
        else
        begin
            far_posted_hdr_credit <= link_ph_credit[7:0];
            far_posted_data_credit <= link_pd_credit[11:0];
            far_nonposted_hdr_credit <= link_nph_credit[7:0];
            far_nonposted_data_credit <= link_npd_credit[11:0];
            far_posted_hdr_unlim <= link_ph_credit[8];
            far_posted_data_unlim <= link_pd_credit[12];
            far_nonposted_hdr_unlim <= link_nph_credit[8];
            far_nonposted_data_unlim <= link_npd_credit[12];
            posted_credit_recheck <= link_p_recheck;
            completion_credit_recheck <= link_cpl_recheck;
            link_ph_release <= posted_hdr_credit_return;
            link_pd_release <= posted_data_credit_return;
            link_nph_release <= nonposted_hdr_credit_return;
            if (posted_data_credit_return)
                link_pd_count <= posted_data_credit_count;
        end
    end

    // Receive: hold one word so the first word can leave with the window hit, which
    // needs the address in the second word. Address check assumes the wide layout.
    reg              h_valid;
    reg              h_start;
    reg              h_end;
    reg              h_crc;
    reg              h_len;
    reg [DATA_W-1:0] h_data;
    reg              rx_drop;
    reg              rx_malf;
    wire [31:0]      rx_addr;
    wire [6:0]       hit_vec;
    wire             h_is_req;
    wire             h_is_cfg;
    wire             block_start;
    wire             emit;
    wire             take;

    assign h_is_cfg    = (h_data[DATA_W-1 -: 8] == `TLPU_CFG0_RD) || (h_data[DATA_W-1 -: 8] == `TLPU_CFG0_WR);
    assign h_is_req    = (h_data[DATA_W-4 -: 5] == `TLPU_TYPE_MEM) || (h_data[DATA_W-4 -: 5] == `TLPU_TYPE_MEML)
                      || (h_data[DATA_W-4 -: 5] == `TLPU_TYPE_IO);
    assign rx_addr     = h_data[DATA_W-3] ? link_rx_data[31:0] : link_rx_data[DATA_W-1 -: 32];
    assign block_start = h_start && !h_is_cfg && recv_valid && recv_end_mark;
    assign emit        = h_valid && (h_end || link_rx_valid) && !block_start;
    assign take        = link_rx_valid && link_rx_ready;
    assign link_rx_ready = !h_valid || (emit && !h_end) || (h_end && !block_start);

    // One comparator per window.
    genvar gi;
    generate
        for (gi = 0; gi < `TLPU_BAR_NUM; gi = gi + 1)
        begin : g_bar
            assign hit_vec[gi] = bar_enable[gi]
                && ((rx_addr & bar_mask[gi*32 +: 32]) == (bar_base[gi*32 +: 32] & bar_mask[gi*32 +: 32]));
        end
    endgenerate

    // Forwarding stage; core configuration packets are swallowed.
    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            h_valid <= 1'b0;
            h_start <= 1'b0;
            h_end <= 1'b0;
            h_crc <= 1'b0;
            h_len <= 1'b0;
            h_data <= {DATA_W{1'b0}};
            rx_drop <= 1'b0;
            rx_malf <= 1'b0;
            recv_valid <= 1'b0;
            recv_start_mark <= 1'b0;
            recv_end_mark <= 1'b0;
            recv_data <= {DATA_W{1'b0}};
            recv_bar_hit <= 7'h00;
            recv_crc_error_flag <= 1'b0;
            recv_malformed_flag <= 1'b0;
            cfg_consumed <= 1'b0;
        end
        else
        begin
            if (take)
            begin
                h_valid <= 1'b1;
                h_start <= link_rx_start;
                h_end   <= link_rx_end;
                h_crc   <= link_rx_crc_err;
                h_len   <= link_rx_len_err;
                h_data  <= link_rx_data;
            end
            else if (emit)
                h_valid <= 1'b0;
            cfg_consumed <= emit && h_start && h_is_cfg;
            if (emit && h_start)
                rx_drop <= h_is_cfg;
            // A length error marks its word and the rest of the packet.
            if (emit && h_end)
                rx_malf <= 1'b0;
            else if (emit && h_len)
                rx_malf <= 1'b1;
            recv_valid <= emit && !(h_start ? h_is_cfg : rx_drop);
            recv_start_mark <= emit && h_start && !h_is_cfg;
            recv_end_mark <= emit && h_end && !(h_start ? h_is_cfg : rx_drop);
            recv_crc_error_flag <= emit && h_end && h_crc && !rx_drop;
            recv_malformed_flag <= emit && (h_len || rx_malf) && !(h_start ? h_is_cfg : rx_drop);
            if (emit)
            begin
                recv_data    <= h_data;
                recv_bar_hit <= (h_start && h_is_req && !h_end) ? hit_vec : 7'h00;
            end
        end
    end
endmodule

// ===== tb/tlpu_core_monitor.sv
// Concurrent checks on the ports of the packet user interface.
module tlpu_core_monitor (
    // Clock and reset.
    input wire        mclk,
    input wire        sys_rst,
    // Transmit handshake and credit.
    input wire        xmit_request,
    input wire        xmit_grant,
    input wire        posted_credit_recheck,
    input wire        link_p_recheck,
    input wire [12:0] link_pd_credit,
    input wire        far_posted_data_unlim,
    // Receive stream.
    input wire        recv_valid,
    input wire        recv_start_mark,
    input wire        recv_end_mark,
    input wire [6:0]  recv_bar_hit,
    input wire        recv_crc_error_flag,
    input wire        recv_malformed_flag,
    // Credit return.
    input wire        posted_hdr_credit_return,
    input wire        posted_data_credit_return,
    input wire [7:0]  posted_data_credit_count,
    input wire        link_ph_release,
    input wire [7:0]  link_pd_count
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // A new grant answers a standing request; within a packet it runs on.
    property p_grant_req; $rose(xmit_grant) |-> xmit_request; endproperty
    a_grant_req: assert property (p_grant_req) else $error("grant without request");
    // A recheck blocks the grant in its own cycle and the next one.
    property p_recheck; posted_credit_recheck |-> !xmit_grant ##1 !xmit_grant; endproperty
    a_recheck: assert property (p_recheck) else $error("grant during recheck");
    property p_recheck_fwd; link_p_recheck |=> posted_credit_recheck; endproperty
    a_recheck_fwd: assert property (p_recheck_fwd) else $error("recheck not forwarded");
    property p_unlim; link_pd_credit[12] |=> far_posted_data_unlim; endproperty
    a_unlim: assert property (p_unlim) else $error("unlimited credit bit lost");
    property p_start; recv_start_mark |-> recv_valid; endproperty
    a_start: assert property (p_start) else $error("start mark without word");
    property p_gap; recv_end_mark |=> !recv_start_mark; endproperty
    a_gap: assert property (p_gap) else $error("no gap after end");
    property p_crc; recv_crc_error_flag |-> recv_end_mark && recv_valid; endproperty
    a_crc: assert property (p_crc) else $error("crc flag not on end");
    property p_malf; recv_malformed_flag |-> recv_valid; endproperty
    a_malf: assert property (p_malf) else $error("malformed flag alone");
    property p_hit; recv_bar_hit != 7'h00 |-> recv_start_mark; endproperty
    a_hit: assert property (p_hit) else $error("hit not on start");
    property p_pd_ret; posted_data_credit_return |=> link_pd_count == $past(posted_data_credit_count); endproperty
    a_pd_ret: assert property (p_pd_ret) else $error("credit count lost");
    property p_ph_ret; posted_hdr_credit_return |=> link_ph_release; endproperty
    a_ph_ret: assert property (p_ph_ret) else $error("header release lost");

    // Main scenarios reached.
    c_rx: cover property (recv_start_mark ##1 recv_end_mark);
    c_tx: cover property (xmit_grant ##1 !xmit_grant);
    c_crc: cover property (recv_crc_error_flag);
endmodule

bind tlpu_core tlpu_core_monitor tlpu_core_monitor_i (.*);

// ===== tb/tlpu_user_model.sv
// Behavioural user logic: sends one staged packet and returns posted credits.
module tlpu_user_model (
    // Clock and reset.
    input  wire        mclk,
    input  wire        sys_rst,
    // Packet staged by the bench.
    input  wire        send,
    input  wire [2:0]  n_words,
    input  wire [63:0] pkt [0:3],
    // Transmit handshake.
    input  wire        xmit_grant,
    output reg         xmit_request,
    output reg         xmit_start_mark,
    output reg         xmit_end_mark,
    output reg  [63:0] xmit_data,
    // Far-end credit.
    input  wire [11:0] far_posted_data_credit,
    input  wire        far_posted_data_unlim,
    // Receive and credit return.
    input  wire        recv_start_mark,
    input  wire        recv_end_mark,
    input  wire [63:0] recv_data,
    output reg         posted_hdr_credit_return,
    output reg         posted_data_credit_return,
    output reg  [7:0]  posted_data_credit_count
);
    reg        pend;
    reg [2:0]  issued;
    reg        is_wr;
    reg [9:0]  rlen;
    wire [9:0] len = pkt[0][41:32];
    wire [7:0] need = len[9:2] + {7'h00, |len[1:0]};
    // The whole packet must fit the far-end data credit unless that is unlimited.
    wire       ok = far_posted_data_unlim || far_posted_data_credit >= {4'h0, need};
    wire       take = pend && xmit_grant;
    wire [2:0] next_issued = send ? 3'h0 : issued + {2'h0, take};

    // Request drops the clock after credit turns short.
    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pend <= 1'b0;
            issued <= 3'h0;
            xmit_request <= 1'b0;
            xmit_start_mark <= 1'b0;
            xmit_end_mark <= 1'b0;
            posted_hdr_credit_return <= 1'b0;
            posted_data_credit_return <= 1'b0;
        end
        else
        begin
            pend <= send || (pend && next_issued != n_words);
            issued <= next_issued;
            xmit_request <= (send || (pend && next_issued == 3'h0)) && ok;
            xmit_start_mark <= take && issued == 3'h0;
            xmit_end_mark <= take && issued == n_words - 3'h1;
            if (take)
                xmit_data <= pkt[issued];
            if (recv_start_mark)
            begin
                is_wr <= recv_data[63:56] == 8'h40;
                rlen  <= recv_data[41:32];
            end
            posted_hdr_credit_return <= recv_end_mark && is_wr;
            posted_data_credit_return <= recv_end_mark && is_wr;
            posted_data_credit_count  <= rlen[9:2] + {7'h00, |rlen[1:0]};
        end
    end
endmodule

// ===== tb/test_tlpu_core.sv
// Self-checking bench of the packet user interface.
module test_tlpu_core;
    timeunit 1ns;
    timeprecision 100ps;

    // Design ports.
    logic         mclk = 1'b0, sys_rst = 1'b1;
    logic         xmit_request, xmit_grant, xmit_start_mark, xmit_end_mark, posted_credit_recheck;
    logic [63:0]  xmit_data, link_tx_data, recv_data, link_rx_data = 64'h0;
    logic [7:0]   far_posted_hdr_credit, far_nonposted_hdr_credit, link_pd_count, posted_data_credit_count;
    logic [11:0]  far_posted_data_credit, far_nonposted_data_credit;
    logic         far_posted_hdr_unlim, far_posted_data_unlim, far_nonposted_hdr_unlim, far_nonposted_data_unlim;
    logic         completion_credit_recheck, link_tx_valid, link_tx_start, link_tx_end, link_rx_ready;
    logic         recv_valid, recv_start_mark, recv_end_mark, recv_crc_error_flag, recv_malformed_flag;
    logic         cfg_consumed, link_ph_release, link_pd_release, link_nph_release;
    logic         posted_hdr_credit_return, posted_data_credit_return;
    logic [6:0]   recv_bar_hit, bar_enable = 7'h01;
    logic [8:0]   link_ph_credit = 9'h100, link_nph_credit = 9'h100;
    logic [12:0]  link_pd_credit = 13'h1000, link_npd_credit = 13'h1000;
    logic         link_p_recheck = 1'b0, link_cpl_recheck = 1'b0, link_tx_ready = 1'b1, send = 1'b0;
    logic         link_rx_valid = 1'b0, link_rx_start = 1'b0, link_rx_end = 1'b0;
    logic         link_rx_crc_err = 1'b0, link_rx_len_err = 1'b0, nonposted_hdr_credit_return = 1'b0;
    logic [223:0] bar_base = 224'h1000_0000, bar_mask = 224'hFFFF_F000;
    logic [2:0]   n_words = 3'h2;
    logic [63:0]  pkt [0:3] = '{default: 64'h0};
    // Bench bookkeeping.
    logic [65:0]  txq[$];
    logic [74:0]  rxq[$];
    logic [7:0]   pdc = 8'h00;
    int           fails = 0, n_checks = 0, gcnt = 0, ccnt = 0;

    tlpu_core tlpu_core_i (.*);
    tlpu_user_model tlpu_user_model_i (.*);

    // Free-running clock.
    always #25 mclk = ~mclk;

    // Record what the design hands out.
    always @(posedge mclk)
    begin
        if (link_tx_valid === 1'b1 && link_tx_ready)
            txq.push_back({link_tx_start, link_tx_end, link_tx_data});
        if (xmit_grant === 1'b1)
            gcnt++;
        if (recv_valid === 1'b1)
            rxq.push_back({recv_start_mark, recv_end_mark, recv_crc_error_flag, recv_malformed_flag,
                           recv_bar_hit, recv_data});
        if (cfg_consumed === 1'b1)
            ccnt++;
        if (link_pd_release === 1'b1)
            pdc = link_pd_count;
    end

    task automatic check(input string what, input logic [74:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        if (fails == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Send the staged packet, optionally with the link stalled.
    task automatic tx_pkt(input logic [2:0] n, input logic stall);
        int k;
        n_words <= n;
        gcnt = 0;
        txq.delete();
        send <= 1'b1;
        link_tx_ready <= !stall;
        @(posedge mclk);
        send <= 1'b0;
        if (stall)
        begin
            repeat (12) @(posedge mclk);
            check("buffer held", {link_tx_valid, 31'(txq.size())}, {1'b1, 31'h0});
            link_tx_ready <= 1'b1;
        end
        for (k = 0; k < 200 && txq.size() < n; k++)
            @(posedge mclk);
        check("grant cycles", gcnt, n);
        for (int i = 0; i < n; i++)
            check("tx word", txq[i], {i == 0, i == n - 1, pkt[i]});
    endtask

    // One receive word, held until the core takes it.
    task automatic rx_word(input logic [63:0] w, input logic st, en, ce, le);
        link_rx_valid   <= 1'b1;
        link_rx_data    <= w;
        link_rx_start   <= st;
        link_rx_end     <= en;
        link_rx_crc_err <= ce;
        link_rx_len_err <= le;
        do @(posedge mclk); while (link_rx_ready !== 1'b1);
    endtask

    // Watchdog; the tests need under a hundred cycles.
    initial
    begin
        repeat (3000) @(posedge mclk);
        fails++;
        stop_test();
    end

    initial
    begin
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        check("grant idle", xmit_grant, 1'b0);
        pkt[0] <= {32'h4000_0001, 32'h0000_000F};
        pkt[1] <= {32'h2000_0000, 32'hCAFE_0001};
        tx_pkt(3'h2, 1'b0);
        pkt[0] <= {32'h4000_0004, 32'h0000_00FF};
        pkt[2] <= {32'h1111_2222, 32'h3333_4444};
        pkt[3] <= {32'h5555_6666, 32'h0000_0000};
        tx_pkt(3'h4, 1'b1);
        // Short credit with a recheck.
        link_pd_credit <= 13'h0000;
        link_p_recheck <= 1'b1;
        @(posedge mclk);
        link_p_recheck <= 1'b0;
        @(posedge mclk);
        fork
            tx_pkt(3'h4, 1'b0);
            begin
                repeat (10) @(posedge mclk);
                check("grant blocked", gcnt, 0);
                link_pd_credit <= 13'h0001;
            end
        join
        // Window-0 write, config read, malformed read with crc error.
        rx_word({32'h4000_0001, 32'h0000_000F}, 1, 0, 0, 0);
        rx_word({32'h1000_0010, 32'h1234_5678}, 0, 1, 0, 0);
        rx_word({32'h0400_0001, 32'h0000_000F}, 1, 0, 0, 0);
        rx_word(64'h0, 0, 1, 0, 0);
        rx_word({32'h0000_0001, 32'h0000_000F}, 1, 0, 0, 1);
        rx_word({32'h2000_0000, 32'h0}, 0, 1, 1, 0);
        link_rx_valid <= 1'b0;
        repeat (10) @(posedge mclk);
        check("rx words", rxq.size(), 4);
        check("rx w0", rxq[0], {4'b1000, 7'h01, 32'h4000_0001, 32'h0000_000F});
        check("rx w1", rxq[1], {4'b0100, 7'h00, 32'h1000_0010, 32'h1234_5678});
        check("rx w2", rxq[2], {4'b1001, 7'h00, 32'h0000_0001, 32'h0000_000F});
        check("rx w3", rxq[3], {4'b0111, 7'h00, 32'h2000_0000, 32'h0});
        check("cfg dropped", ccnt, 1);
        check("credit count", pdc, 8'h01);
        stop_test();
    end
endmodule
